/* test/ble_partner.sv */
// Register file and data memory model facing the execution block.
`timescale 1ns/1ps
`default_nettype none
module ble_partner (
   input wire logic ref_clk_in, // System clock.
   input wire logic [4:0] rf_a_addr_in, // Pair read address.
   output logic [15:0] rf_a_data_out, // Registers a+1 and a.
   input wire logic [4:0] rf_b_addr_in, // Byte read address.
   output logic [7:0] rf_b_data_out, // Register b.
   input wire ble_pkg::ble_rf_wr_t rf_wr_in, // Register write.
   input wire ble_pkg::ble_mem_req_t mem_req_in, // Memory request.
   output logic [7:0] mem_rdata_out // Memory read data.
);
   import ble_pkg::*;
   logic [7:0] rf [0:31];
   logic [7:0] mem [0:1023];
   logic [7:0] last_r;
   logic [4:0] a_hi;
   // Pair reads take the next register up (a+1) as the high byte.
   assign a_hi = rf_a_addr_in + 5'h01;
   assign rf_a_data_out = {rf[a_hi], rf[rf_a_addr_in]};
   assign rf_b_data_out = rf[rf_b_addr_in];
   // Outside a read the data lines toggle, so stale data cannot match.
   assign mem_rdata_out = (mem_req_in.valid && !mem_req_in.we) ?
      mem[mem_req_in.addr[9:0]] : ~last_r;
   // Writes land at the clock edge; memory is mirrored above 1 KiB.
   always @(posedge ref_clk_in) begin
      last_r <= mem_rdata_out;
      if (rf_wr_in.we_lo) begin
         rf[rf_wr_in.addr] <= rf_wr_in.data[7:0];
      end
      if (rf_wr_in.we_hi) begin
         rf[rf_wr_in.addr + 5'h01] <= rf_wr_in.data[15:8];
      end
      if (mem_req_in.valid && mem_req_in.we) begin
         mem[mem_req_in.addr[9:0]] <= mem_req_in.wdata;
      end
   end
endmodule
`default_nettype wire

/* test/test_ble_exec.sv */
// Self-checking testbench of the bit and load/store execution block.
`timescale 1ns/1ps
`default_nettype none
module test_ble_exec;
   import ble_pkg::*;
   logic ref_clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic ce_in = 1'b1;
   logic cmd_valid_in = 1'b0;
   ble_cmd_t cmd_in = '0;
   logic cmd_ready_out;
   logic [4:0] rf_a_addr, rf_b_addr;
   logic [15:0] rf_a_data;
   logic [7:0] rf_b_data, mem_rdata, status_out, reg_rdata_out;
   ble_rf_wr_t rf_wr;
   ble_mem_req_t mem_req;
   logic [3:0] reg_addr_in = 4'h0;
   logic [7:0] reg_wdata_in = 8'h00;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   int n_mismatch = 0;
   int samples_checked = 0;
   int cycles = 0;
   ble_exec dut_u (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
      .ce_in(ce_in), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
      .cmd_ready_out(cmd_ready_out), .rf_a_addr_out(rf_a_addr),
      .rf_a_data_in(rf_a_data), .rf_b_addr_out(rf_b_addr),
      .rf_b_data_in(rf_b_data), .rf_wr_out(rf_wr), .mem_req_out(mem_req),
      .mem_rdata_in(mem_rdata), .status_out(status_out),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out));
   ble_partner pm_u (.ref_clk_in(ref_clk_in), .rf_a_addr_in(rf_a_addr),
      .rf_a_data_out(rf_a_data), .rf_b_addr_in(rf_b_addr),
      .rf_b_data_out(rf_b_data), .rf_wr_in(rf_wr), .mem_req_in(mem_req),
      .mem_rdata_out(mem_rdata));
   // Clock at 50 MHz.
   always #10 ref_clk_in = ~ref_clk_in;
   // A hang is cut short well beyond the expected run length.
   always @(posedge ref_clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_mismatch = n_mismatch + 1;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One-cycle register port write, strobe dropped at the next edge.
   task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge ref_clk_in);
      reg_wr_in <= 1'b0;
   endtask
   // Read data is taken in the cycle right after the strobe.
   task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
      @(posedge ref_clk_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge ref_clk_in);
      reg_rd_in <= 1'b0;
      @(posedge ref_clk_in);
      d = reg_rdata_out;
   endtask
   // Offer a command until taken, then let it complete.
   task automatic issue(input ble_cmd_t c);
      int i;
      @(posedge ref_clk_in);
      cmd_valid_in <= 1'b1;
      cmd_in <= c;
      i = 0;
      do begin
         @(posedge ref_clk_in);
         i++;
      end while (cmd_ready_out !== 1'b1 && i < 10);
      cmd_valid_in <= 1'b0;
      cmd_in <= '0;
      repeat (3) @(posedge ref_clk_in);
   endtask
   // Run a one-byte operation on register rd and judge result and flags.
   task automatic unit_op(input ble_op_t op, input logic [7:0] st,
      input logic [7:0] v, input logic [2:0] b, input logic [7:0] er,
      input logic [7:0] es);
      ble_cmd_t c;
      c = '0;
      reg_write(REG_STATUS, st);
      pm_u.rf[16] = v;
      c.op = op;
      c.rd = 5'd16;
      c.rr = 5'd16;
      c.bit_sel = b;
      issue(c);
      chk("unit result", {8'h00, er}, {8'h00, pm_u.rf[16]});
      chk("unit status", {8'h00, es}, {8'h00, status_out});
      $display("unit op %0d done", op);
   endtask
   task automatic flag_ops();
      ble_op_t ops [6];
      int bits [6];
      logic [7:0] st;
      ops = '{OP_SET_SIGN_FLAG, OP_CLEAR_SIGN_FLAG, OP_SET_OVERFLOW_FLAG,
              OP_CLEAR_OVERFLOW_FLAG, OP_SET_HALF_CARRY, OP_CLEAR_HALF_CARRY};
      bits = '{SR_S, SR_S, SR_V, SR_V, SR_H, SR_H};
      for (int i = 0; i < 6; i++) begin
         st = (i % 2 == 0) ? 8'h00 : 8'hff;
         unit_op(ops[i], st, 8'h5a, 3'h0, 8'h5a, st ^ (8'h01 << bits[i]));
      end
   endtask
   // Pair copy of R3:R2 into R5:R4 with flags kept.
   task automatic pair_copy();
      ble_cmd_t c;
      c = '0;
      reg_write(REG_STATUS, 8'h2b);
      pm_u.rf[2] = 8'h34;
      pm_u.rf[3] = 8'h12;
      c.op = OP_REGISTER_PAIR_COPY;
      c.rd = 5'd4;
      c.rr = 5'd2;
      issue(c);
      chk("pair", 16'h1234, {pm_u.rf[5], pm_u.rf[4]});
      chk("pair status", 16'h002b, {8'h00, status_out});
      $display("pair copy done");
   endtask
   // Memory access through a pointer; ea is the expected address used.
   task automatic mem_case(input ble_op_t op, input ble_ptr_t p,
      input ble_mode_t m, input logic [5:0] d, input logic [15:0] k,
      input logic [15:0] pv, input logic [15:0] ea, input logic [15:0] ep);
      ble_cmd_t c;
      logic [4:0] lo;
      c = '0;
      lo = (p == PTR_X) ? PTR_X_LO : (p == PTR_Y) ? PTR_Y_LO : PTR_Z_LO;
      reg_write(REG_STATUS, 8'h2b);
      pm_u.rf[lo] = pv[7:0];
      pm_u.rf[lo + 5'h01] = pv[15:8];
      pm_u.mem[ea[9:0]] = 8'h5a ^ ea[7:0];
      pm_u.rf[8] = 8'h3c;
      c.op = op;
      c.rd = 5'd8;
      c.rr = 5'd8;
      c.ptr = p;
      c.mode = m;
      c.disp = d;
      c.addr = k;
      issue(c);
      chk("pointer", ep, {pm_u.rf[lo + 5'h01], pm_u.rf[lo]});
      if (op == OP_INDIRECT_MEMORY_WRITE) begin
         chk("stored", 16'h003c, {8'h00, pm_u.mem[ea[9:0]]});
      end else begin
         chk("loaded", {8'h00, 8'h5a ^ ea[7:0]}, {8'h00, pm_u.rf[8]});
      end
      chk("mem status", 16'h002b, {8'h00, status_out});
      $display("memory op %0d mode %0d done", op, m);
   endtask
   // Status read back and an unmapped read.
   task automatic reg_port();
      logic [7:0] d;
      reg_write(REG_STATUS, 8'h96);
      reg_read(REG_STATUS, d);
      chk("status read", 16'h0096, {8'h00, d});
      reg_read(4'hf, d);
      chk("unmapped read", 16'h0000, {8'h00, d});
      reg_read(REG_STATE, d);
      chk("state read", 16'h0000, {8'h00, d});
      $display("register port done");
   endtask
   // A write offered while the clock enable is low must not land, since
   // every flop of the block, the register port included, is frozen.
   task automatic ce_hold();
      @(posedge ref_clk_in);
      ce_in <= 1'b0;
      reg_write(REG_STATUS, 8'h11);
      ce_in <= 1'b1;
      @(posedge ref_clk_in);
      chk("frozen status", 16'h0096, {8'h00, status_out});
      $display("clock enable hold done");
   endtask
   initial begin
      repeat (20) @(posedge ref_clk_in);
      resetn_in <= 1'b1;
      for (int i = 0; i < 32; i++) pm_u.rf[i] = 8'h00;
      chk("status reset", {8'h00, STATUS_RST}, {8'h00, status_out});
      unit_op(OP_ROTATE_RIGHT_CARRY, 8'h01, 8'h81, 3'h0, 8'hc0, 8'h05);
      unit_op(OP_ROTATE_RIGHT_CARRY, 8'h00, 8'h01, 3'h0, 8'h00, 8'h0b);
      unit_op(OP_ARITH_SHIFT_RIGHT, 8'h00, 8'h80, 3'h0, 8'hc0, 8'h0c);
      unit_op(OP_ARITH_SHIFT_RIGHT, 8'h20, 8'h41, 3'h0, 8'h20, 8'h29);
      unit_op(OP_BIT_TO_T_FLAG, 8'h2b, 8'h20, 3'h5, 8'h20, 8'h6b);
      unit_op(OP_BIT_TO_T_FLAG, 8'hff, 8'hdf, 3'h5, 8'hdf, 8'hbf);
      unit_op(OP_T_FLAG_TO_BIT, 8'h40, 8'h00, 3'h3, 8'h08, 8'h40);
      unit_op(OP_T_FLAG_TO_BIT, 8'hbf, 8'hff, 3'h7, 8'h7f, 8'hbf);
      flag_ops();
      pair_copy();
      mem_case(OP_INDIRECT_MEMORY_READ, PTR_X, AM_POST_INC, 6'h00, 16'h0000,
         16'h00ff, 16'h00ff, 16'h0100);
      mem_case(OP_INDIRECT_MEMORY_READ, PTR_Y, AM_PRE_DEC, 6'h00, 16'h0000,
         16'h0100, 16'h00ff, 16'h00ff);
      mem_case(OP_DISPLACED_MEMORY_READ, PTR_Z, AM_PLAIN, 6'h3f, 16'h0000,
         16'h0010, 16'h004f, 16'h0010);
      mem_case(OP_DIRECT_MEMORY_READ, PTR_Z, AM_PLAIN, 6'h00, 16'h0230,
         16'h0010, 16'h0230, 16'h0010);
      mem_case(OP_INDIRECT_MEMORY_WRITE, PTR_Y, AM_POST_INC, 6'h00, 16'h0000,
         16'h01ff, 16'h01ff, 16'h0200);
      mem_case(OP_INDIRECT_MEMORY_WRITE, PTR_Z, AM_PRE_DEC, 6'h00, 16'h0000,
         16'h0300, 16'h02ff, 16'h02ff);
      mem_case(OP_INDIRECT_MEMORY_READ, PTR_Z, AM_PLAIN, 6'h00, 16'h0000,
         16'h0123, 16'h0123, 16'h0123);
      mem_case(OP_INDIRECT_MEMORY_WRITE, PTR_X, AM_PLAIN, 6'h00, 16'h0000,
         16'h0040, 16'h0040, 16'h0040);
      reg_port();
      ce_hold();
      end_sim();
   end
endmodule
`default_nettype wire

/* verilog/ble_exec.sv */
// Execution of bit, flag and data transfer operations for an 8-bit core.
`timescale 1ns/1ps
`default_nettype none
module ble_exec (
   input wire logic ref_clk_in, // System clock, 50 MHz.
   input wire logic resetn_in, // Synchronous reset, active low.
   input wire logic ce_in, // Clock enable, freezes state when low.
   input wire logic cmd_valid_in, // Decoded instruction offered.
   input wire ble_pkg::ble_cmd_t cmd_in, // Decoded instruction.
   output logic cmd_ready_out, // Ready in the issue phase, even while ce_in is low.
   output logic [4:0] rf_a_addr_out, // Pair read address.
   input wire logic [15:0] rf_a_data_in, // Registers a+1 and a.
   output logic [4:0] rf_b_addr_out, // Byte read address.
   input wire logic [7:0] rf_b_data_in, // Register b.
   output ble_pkg::ble_rf_wr_t rf_wr_out, // Register file write.
   output ble_pkg::ble_mem_req_t mem_req_out, // Data memory request.
   input wire logic [7:0] mem_rdata_in, // Read data during request.
   output logic [7:0] status_out, // Status register.
   input wire logic [3:0] reg_addr_in, // Register port address.
   input wire logic [7:0] reg_wdata_in, // Register port write data.
   input wire logic reg_wr_in, // Register port write strobe.
   input wire logic reg_rd_in, // Register port read strobe.
   output logic [7:0] reg_rdata_out // Read data, one cycle later.
);
   import ble_pkg::*;

   typedef enum logic {PH_ISSUE, PH_MEM} ble_phase_t;

   ble_phase_t phase_r;
   ble_phase_t phase_nxt;
   logic [7:0] status_r;
   logic [7:0] status_nxt;
   ble_rf_wr_t rf_wr_r;
   ble_rf_wr_t rf_wr_nxt;
   ble_mem_req_t mem_req_r;
   ble_mem_req_t mem_req_nxt;
   logic [4:0] load_rd_r;
   logic [4:0] load_rd_nxt;
   logic load_pend_r;
   logic load_pend_nxt;
   logic [7:0] reg_rdata_r;
   logic [7:0] reg_rdata_nxt;

   logic fire;
   logic [4:0] ptr_lo;
   logic [15:0] pair_a;
   logic [7:0] val_b;
   logic [15:0] ptr_new;
   logic [15:0] eff_addr;
   logic ptr_upd;
   logic [7:0] fu_result;
   logic [7:0] fu_status;

   // The register file writes at the end of the cycle in which our write
   // stands, so a dependent read in that cycle would see the old value.
   function automatic logic [7:0] fwd_byte(input logic [4:0] a,
                                            input logic [7:0] raw,
                                            input ble_rf_wr_t w);
      logic [7:0] v;
      v = raw;
      if (w.we_lo && w.addr == a) begin
         v = w.data[7:0];
      end
      if (w.we_hi && 5'(w.addr + 5'h01) == a) begin
         v = w.data[15:8];
      end
      return v;
   endfunction

   // An instruction is taken only in the issue phase and while enabled.
   assign cmd_ready_out = (phase_r == PH_ISSUE);
   assign fire = ce_in && cmd_valid_in && (phase_r == PH_ISSUE);

   // Pointer pair selection.
   always_comb begin
      unique case (cmd_in.ptr)
         PTR_X: ptr_lo = PTR_X_LO;
         PTR_Y: ptr_lo = PTR_Y_LO;
         PTR_Z: ptr_lo = PTR_Z_LO;
         default: ptr_lo = PTR_Z_LO;
      endcase
   end

   // Read addresses: pair port for pointers and pair copies, byte port
   // for the single operand of bit, shift and store operations.
   always_comb begin
      if (cmd_in.op == OP_REGISTER_PAIR_COPY) begin
         rf_a_addr_out = cmd_in.rr;
      end else begin
         rf_a_addr_out = ptr_lo;
      end
      if (cmd_in.op == OP_ROTATE_RIGHT_CARRY ||
          cmd_in.op == OP_ARITH_SHIFT_RIGHT ||
          cmd_in.op == OP_T_FLAG_TO_BIT) begin
         rf_b_addr_out = cmd_in.rd;
      end else begin
         rf_b_addr_out = cmd_in.rr;
      end
   end

   // Operand values with the pending write forwarded.
   assign pair_a = {fwd_byte(5'(rf_a_addr_out + 5'h01), rf_a_data_in[15:8],
                             rf_wr_r),
                    fwd_byte(rf_a_addr_out, rf_a_data_in[7:0], rf_wr_r)};
   assign val_b = fwd_byte(rf_b_addr_out, rf_b_data_in, rf_wr_r);

   // Effective address and pointer update, full 16-bit arithmetic.
   always_comb begin
      eff_addr = pair_a;
      ptr_new = pair_a;
      ptr_upd = 1'b0;
      if (cmd_in.op == OP_DIRECT_MEMORY_READ) begin
         eff_addr = cmd_in.addr;
      end else if (cmd_in.op == OP_DISPLACED_MEMORY_READ) begin
         eff_addr = pair_a + {10'h000, cmd_in.disp};
      end else begin
         unique case (cmd_in.mode)
            AM_POST_INC: begin
               ptr_new = pair_a + 16'h0001;
               ptr_upd = 1'b1;
            end
            AM_PRE_DEC: begin
               ptr_new = pair_a - 16'h0001;
               eff_addr = ptr_new;
               ptr_upd = 1'b1;
            end
            default: begin
               ptr_upd = 1'b0;
            end
         endcase
      end
   end

   // Shift and flag datapath.
   ble_flag_unit u_flag (
      .op_in(cmd_in.op),
      .value_in(val_b),
      .bit_sel_in(cmd_in.bit_sel),
      .status_in(status_r),
      .result_out(fu_result),
      .status_out(fu_status)
   );

   // Next state of the sequencer. An instruction's flag update wins over
   // a software write to the status register in the same cycle.
   always_comb begin
      phase_nxt = phase_r;
      status_nxt = status_r;
      rf_wr_nxt = '0;
      mem_req_nxt = '0;
      load_rd_nxt = load_rd_r;
      load_pend_nxt = load_pend_r;
      if (reg_wr_in && reg_addr_in == REG_STATUS) begin
         status_nxt = reg_wdata_in;
      end
      unique case (phase_r)
         PH_ISSUE: begin
            if (cmd_valid_in) begin
               unique case (cmd_in.op)
                  OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT: begin
                     status_nxt = fu_status;
                     rf_wr_nxt.we_lo = 1'b1;
                     rf_wr_nxt.addr = cmd_in.rd;
                     rf_wr_nxt.data = {8'h00, fu_result};
                  end
                  OP_T_FLAG_TO_BIT: begin
                     rf_wr_nxt.we_lo = 1'b1;
                     rf_wr_nxt.addr = cmd_in.rd;
                     rf_wr_nxt.data = {8'h00, fu_result};
                  end
                  OP_BIT_TO_T_FLAG, OP_SET_SIGN_FLAG, OP_CLEAR_SIGN_FLAG,
                  OP_SET_OVERFLOW_FLAG, OP_CLEAR_OVERFLOW_FLAG,
                  OP_SET_HALF_CARRY, OP_CLEAR_HALF_CARRY: begin
                     status_nxt = fu_status;
                  end
                  OP_REGISTER_PAIR_COPY: begin
                     rf_wr_nxt.we_lo = 1'b1;
                     rf_wr_nxt.we_hi = 1'b1;
                     rf_wr_nxt.addr = cmd_in.rd;
                     rf_wr_nxt.data = pair_a;
                  end
                  OP_INDIRECT_MEMORY_READ, OP_DISPLACED_MEMORY_READ,
                  OP_DIRECT_MEMORY_READ, OP_INDIRECT_MEMORY_WRITE: begin
                     // First cycle: request out, pointer written back.
                     mem_req_nxt.valid = 1'b1;
                     mem_req_nxt.we =
                        (cmd_in.op == OP_INDIRECT_MEMORY_WRITE);
                     mem_req_nxt.addr = eff_addr;
                     mem_req_nxt.wdata = val_b;
                     rf_wr_nxt.we_lo = ptr_upd;
                     rf_wr_nxt.we_hi = ptr_upd;
                     rf_wr_nxt.addr = ptr_lo;
                     rf_wr_nxt.data = ptr_new;
                     load_pend_nxt = !mem_req_nxt.we;
                     load_rd_nxt = cmd_in.rd;
                     phase_nxt = PH_MEM;
                  end
                  default: begin
                     phase_nxt = PH_ISSUE;
                  end
               endcase
            end
         end
         PH_MEM: begin
            // Second cycle: the memory answers, the destination is written.
            phase_nxt = PH_ISSUE;
            rf_wr_nxt.we_lo = load_pend_r;
            rf_wr_nxt.addr = load_rd_r;
            rf_wr_nxt.data = {8'h00, mem_rdata_in};
            load_pend_nxt = 1'b0;
         end
      endcase
   end

   // Register port read data; unmapped offsets read as zero.
   always_comb begin
      reg_rdata_nxt = 8'h00;
      if (reg_rd_in && reg_addr_in == REG_STATUS) begin
         reg_rdata_nxt = status_r;
      end else if (reg_rd_in && reg_addr_in == REG_STATE) begin
         reg_rdata_nxt = {7'h00, phase_r == PH_MEM};
      end
   end

   // State registers, all frozen while the clock enable is low.
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         phase_r <= PH_ISSUE;
         status_r <= STATUS_RST;
         rf_wr_r <= '0;
         mem_req_r <= '0;
         load_rd_r <= 5'h00;
         load_pend_r <= 1'b0;
         reg_rdata_r <= 8'h00;
      end else if (ce_in) begin
         phase_r <= phase_nxt;
         status_r <= status_nxt;
         rf_wr_r <= rf_wr_nxt;
         mem_req_r <= mem_req_nxt;
         load_rd_r <= load_rd_nxt;
         load_pend_r <= load_pend_nxt;
         reg_rdata_r <= reg_rdata_nxt;
      end
   end

   assign rf_wr_out = rf_wr_r;
   assign mem_req_out = mem_req_r;
   assign status_out = status_r;
   assign reg_rdata_out = reg_rdata_r;

   // Checks on the results registered by a taken instruction.
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);

   ror_result_a: assert property (
      fire && cmd_in.op == OP_ROTATE_RIGHT_CARRY |=>
      rf_wr_r.data[7:0] == {$past(status_r[SR_C]), $past(val_b[7:1])} &&
      status_r[SR_C] == $past(val_b[0]))
      else $error("Rotate right result or carry wrong.");

   asr_sign_a: assert property (
      fire && cmd_in.op == OP_ARITH_SHIFT_RIGHT |=>
      rf_wr_r.data[7:0] == {$past(val_b[7]), $past(val_b[7:1])} &&
      status_r[SR_N] == $past(val_b[7]))
      else $error("Arithmetic shift lost the sign bit.");

   bst_t_only_a: assert property (
      fire && cmd_in.op == OP_BIT_TO_T_FLAG |=>
      status_r[SR_T] == $past(val_b[cmd_in.bit_sel]) &&
      status_r[5:0] == $past(status_r[5:0]))
      else $error("T flag copy wrong or other flags changed.");

   bld_no_flags_a: assert property (
      fire && cmd_in.op == OP_T_FLAG_TO_BIT |=>
      status_r == $past(status_r) && rf_wr_r.we_lo &&
      rf_wr_r.data[$past(cmd_in.bit_sel)] == status_r[SR_T])
      else $error("Bit load from T changed flags or bit.");

   sign_set_a: assert property (
      fire && cmd_in.op == OP_SET_SIGN_FLAG |=>
      status_r[SR_S] && status_r[3:0] == $past(status_r[3:0]))
      else $error("Sign flag not set alone.");

   ovf_set_a: assert property (
      fire && cmd_in.op == OP_SET_OVERFLOW_FLAG |=>
      status_r[SR_V] && status_r[2:0] == $past(status_r[2:0]))
      else $error("Overflow flag not set alone.");

   ovf_clear_a: assert property (
      fire && cmd_in.op == OP_CLEAR_OVERFLOW_FLAG |=>
      !status_r[SR_V] && status_r[7:4] == $past(status_r[7:4]))
      else $error("Overflow flag not cleared alone.");

   half_set_a: assert property (
      fire && cmd_in.op == OP_SET_HALF_CARRY |=>
      status_r[SR_H] && status_r[4:0] == $past(status_r[4:0]))
      else $error("Half carry not set alone.");

   pair_copy_a: assert property (
      fire && cmd_in.op == OP_REGISTER_PAIR_COPY |=>
      rf_wr_r.we_lo && rf_wr_r.we_hi && rf_wr_r.data == $past(pair_a))
      else $error("Register pair copy wrong.");

   post_inc_a: assert property (
      fire && cmd_in.op == OP_INDIRECT_MEMORY_READ &&
      cmd_in.mode == AM_POST_INC |=>
      mem_req_r.addr == $past(pair_a) && !cmd_ready_out &&
      rf_wr_r.data == 16'($past(pair_a) + 16'h0001))
      else $error("Post-increment read address or pointer wrong.");

   pre_dec_a: assert property (
      fire && cmd_in.op == OP_INDIRECT_MEMORY_READ &&
      cmd_in.mode == AM_PRE_DEC |=>
      mem_req_r.addr == 16'($past(pair_a) - 16'h0001) &&
      rf_wr_r.data == mem_req_r.addr)
      else $error("Pre-decrement read address wrong.");
endmodule
`default_nettype wire

/* verilog/ble_flag_unit.sv */
// Shift, bit-move and flag-forcing datapath of the execution block.
`timescale 1ns/1ps
`default_nettype none
module ble_flag_unit (
   input wire ble_pkg::ble_op_t op_in, // Operation in execution.
   input wire logic [7:0] value_in, // Register operand.
   input wire logic [2:0] bit_sel_in, // Selected bit number.
   input wire logic [7:0] status_in, // Current status register.
   output logic [7:0] result_out, // Register result.
   output logic [7:0] status_out // Status register result.
);
   import ble_pkg::*;

   // All results are combinational; the caller registers them.
   always_comb begin
      result_out = value_in;
      status_out = status_in;
      unique case (op_in)
         OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT: begin
            // Carry in on the rotate, sign kept on the shift.
            if (op_in == OP_ROTATE_RIGHT_CARRY) begin
               result_out = {status_in[SR_C], value_in[7:1]};
            end else begin
               result_out = {value_in[7], value_in[7:1]};
            end
            status_out[SR_C] = value_in[0];
            status_out[SR_N] = result_out[7];
            status_out[SR_V] = result_out[7] ^ value_in[0];
            status_out[SR_Z] = (result_out == 8'h00);
         end
         OP_BIT_TO_T_FLAG: begin
            status_out[SR_T] = value_in[bit_sel_in];
         end
         OP_T_FLAG_TO_BIT: begin
            result_out[bit_sel_in] = status_in[SR_T];
         end
         OP_SET_SIGN_FLAG: begin
            status_out[SR_S] = 1'b1;
         end
         OP_CLEAR_SIGN_FLAG: begin
            status_out[SR_S] = 1'b0;
         end
         OP_SET_OVERFLOW_FLAG: begin
            status_out[SR_V] = 1'b1;
         end
         OP_CLEAR_OVERFLOW_FLAG: begin
            status_out[SR_V] = 1'b0;
         end
         OP_SET_HALF_CARRY: begin
            status_out[SR_H] = 1'b1;
         end
         OP_CLEAR_HALF_CARRY: begin
            status_out[SR_H] = 1'b0;
         end
         default: begin
            // Transfer operations leave value and flags alone.
            result_out = value_in;
         end
      endcase
   end
endmodule
`default_nettype wire

/* verilog/ble_pkg.sv */
// Shared constants and types for the bit and load/store execution block.
package ble_pkg;

   // Status register bit positions.
   localparam int SR_C = 0;
   localparam int SR_Z = 1;
   localparam int SR_N = 2;
   localparam int SR_V = 3;
   localparam int SR_S = 4;
   localparam int SR_H = 5;
   localparam int SR_T = 6;
   localparam int SR_I = 7;

   // Value of the status register after reset.
   localparam logic [7:0] STATUS_RST = 8'h00;

   // Low register of each 16-bit pointer pair.
   localparam logic [4:0] PTR_X_LO = 5'h1a;
   localparam logic [4:0] PTR_Y_LO = 5'h1c;
   localparam logic [4:0] PTR_Z_LO = 5'h1e;

   // Plain register port offsets.
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_STATE = 4'h1;

   // Occupancy of each operation class in clock cycles.
   localparam int SIMPLE_CYCLES = 1;
   localparam int MEM_CYCLES = 2;

   // Operations handed over by the instruction fetch stage.
   typedef enum logic [4:0] {
      OP_NOP,
      OP_ROTATE_RIGHT_CARRY,
      OP_ARITH_SHIFT_RIGHT,
      OP_BIT_TO_T_FLAG,
      OP_T_FLAG_TO_BIT,
      OP_SET_SIGN_FLAG,
      OP_CLEAR_SIGN_FLAG,
      OP_SET_OVERFLOW_FLAG,
      OP_CLEAR_OVERFLOW_FLAG,
      OP_SET_HALF_CARRY,
      OP_CLEAR_HALF_CARRY,
      OP_REGISTER_PAIR_COPY,
      OP_INDIRECT_MEMORY_READ,
      OP_DISPLACED_MEMORY_READ,
      OP_DIRECT_MEMORY_READ,
      OP_INDIRECT_MEMORY_WRITE
   } ble_op_t;

   typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} ble_ptr_t;

   typedef enum logic [1:0] {AM_PLAIN, AM_POST_INC, AM_PRE_DEC} ble_mode_t;

   // One decoded instruction.
   typedef struct packed {
      ble_op_t op;
      logic [4:0] rd;
      logic [4:0] rr;
      logic [2:0] bit_sel;
      ble_ptr_t ptr;
      ble_mode_t mode;
      logic [5:0] disp;
      logic [15:0] addr;
   } ble_cmd_t;

   // Data memory request.
   typedef struct packed {
      logic valid;
      logic we;
      logic [15:0] addr;
      logic [7:0] wdata;
   } ble_mem_req_t;

   // Register file write, one or two bytes at addr and addr+1.
   typedef struct packed {
      logic we_lo;
      logic we_hi;
      logic [4:0] addr;
      logic [15:0] data;
   } ble_rf_wr_t;

endpackage
